// >>> src/fpm_menu.v
// Front-panel controller: two buttons, menus, digit entry, I/O LEDs.
// Assumes sync inputs on sys_clk and an Avalon-MM master for settings.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`include "fpm_consts.vh"
module fpm_menu #(
  parameter DEB_CYC = `FPM_DEBOUNCE_CYC,
  parameter HOLD_CYC = `FPM_HOLD_CYC,
  parameter BOTH_CYC = `FPM_BOTH_CYC,
  parameter IDLE_CYC = `FPM_IDLE_CYC,
  parameter FREQ_CYC = `FPM_FREQ_CYC,
  parameter ROT_UNIT = `FPM_CLK_MHZ * 1000000
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Front-panel buttons, high while pressed
  input wire button_one,
  input wire button_two,
  // Group one relay drive state
  input wire relay_output_one_in,
  input wire relay_output_two_in,
  // Group two channel sense and drive
  input wire [2:0] g2_signal_in,
  input wire [2:0] g2_drive_in,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Display and status
  output reg programming_mode_marker,
  output reg current_ratio_menu_marker,
  output reg voltage_ratio_menu_marker,
  output reg relay_output_one,
  output reg relay_output_two,
  output reg [2:0] menu_index,
  output reg [2:0] screen_index,
  output reg [2:0] flash_digit,
  output reg password_screen,
  output reg [11:0] edit_value,
  output reg [2:0] led_green,
  output reg [2:0] led_red,
  output reg [2:0] g2_dir_out,
  output reg meas_settled
);
  // ****************************************************************
  // States, one-hot
  // ****************************************************************
  localparam ST_DISP = 4'b0001;
  localparam ST_PASS = 4'b0010;
  localparam ST_MENU = 4'b0100;
  localparam ST_EDIT = 4'b1000;
  // Digit position 3 means whole number flashing (point shift)
  localparam [2:0] POS_WHOLE = 3'd3;
  localparam [2:0] POS_SEC = 3'd4;

  // Forward or back step of a BCD digit
  function [3:0] bcd_step;
    input [3:0] v;
    input up;
    begin
      if (up)
        bcd_step = (v == 4'h9) ? 4'h0 : v + 4'h1;
      else
        bcd_step = (v == 4'h0) ? 4'h9 : v - 4'h1;
    end
  endfunction

  // Cyclic step of a three-bit index between zero and last
  function [2:0] idx_step;
    input [2:0] v;
    input [2:0] last;
    input up;
    begin
      if (up)
        idx_step = (v == last) ? 3'd0 : v + 3'd1;
      else
        idx_step = (v == 3'd0) ? last : v - 3'd1;
    end
  endfunction

  // ****************************************************************
  // Button debounce and press classification
  // ****************************************************************
  wire [1:0] btn_raw = {button_two, button_one};
  wire [1:0] btn_lvl;
  wire [1:0] short_p;
  wire [1:0] long_p;
  reg both_q;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_btn
      reg [31:0] deb_cnt_q;
      reg [31:0] hold_cnt_q;
      reg lvl_q;
      reg fired_q;
      reg short_q;
      reg long_q;
      // Each channel owns its flops; only these wires are shared
      assign btn_lvl[gi] = lvl_q;
      assign short_p[gi] = short_q;
      assign long_p[gi] = long_q;
      // Level must stay changed for the whole window to count
      always @(posedge sys_clk) begin
        if (!reset_n) begin
          deb_cnt_q <= 32'h0000_0000;
          lvl_q <= 1'b0;
        end else if (btn_raw[gi] == lvl_q) begin
          deb_cnt_q <= 32'h0000_0000;
        end else if (deb_cnt_q >= DEB_CYC - 1) begin
          deb_cnt_q <= 32'h0000_0000;
          lvl_q <= btn_raw[gi];
        end else begin
          deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
        end
      end
      // Hold timer; a long press fires once, a short one on release
      always @(posedge sys_clk) begin
        if (!reset_n) begin
          hold_cnt_q <= 32'h0000_0000;
          fired_q <= 1'b0;
          short_q <= 1'b0;
          long_q <= 1'b0;
        end else begin
          short_q <= 1'b0;
          long_q <= 1'b0;
          if (lvl_q) begin
            if (hold_cnt_q != 32'hFFFF_FFFF)
              hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            if (hold_cnt_q == HOLD_CYC - 1 && !both_q) begin
              long_q <= 1'b1;
              fired_q <= 1'b1;
            end
          end else begin
            hold_cnt_q <= 32'h0000_0000;
            fired_q <= 1'b0;
            if (hold_cnt_q != 32'h0000_0000 && !fired_q && !both_q)
              short_q <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Both-button hold; the chord suppresses single presses until release
  reg [31:0] both_cnt_q;
  reg both_p;
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      both_cnt_q <= 32'h0000_0000;
      both_q <= 1'b0;
      both_p <= 1'b0;
    end else begin
      both_p <= 1'b0;
      if (btn_lvl == 2'b11) begin
        both_q <= 1'b1;
        if (both_cnt_q == BOTH_CYC - 1)
          both_p <= 1'b1;
        if (both_cnt_q != 32'hFFFF_FFFF)
          both_cnt_q <= both_cnt_q + 32'h0000_0001;
      end else begin
        both_cnt_q <= 32'h0000_0000;
        if (btn_lvl == 2'b00)
          both_q <= 1'b0;
      end
    end
  end
  wire b1_any = short_p[0] | long_p[0];
  wire b2_any = short_p[1] | long_p[1];
  wire b2_up = short_p[1];

  // ****************************************************************
  // Settings held by bus and panel
  // ****************************************************************
  reg [31:0] ctrl_q;
  reg [11:0] password_q;
  reg [31:0] ct_q;
  reg [31:0] vt_q;
  reg [31:0] rot_q;
  reg [31:0] profile_q;
  reg [31:0] clock_q;
  reg [3:0] state_q;
  reg [11:0] work_q;
  reg [1:0] point_q;
  reg sec5_q;
  reg [35:0] idle_cnt_q; // Sixty seconds of cycles needs over 32 bits
  reg [31:0] rot_cnt_q;
  reg [31:0] freq_cnt_q;
  wire [3:0] wsel = avs_address[5:2];
  wire wr_hit = avs_write && avs_waitrequest == 1'b0;
  // Nibble of the work value under the flashing digit
  wire [3:0] cur_nib = (flash_digit == 3'd0) ? work_q[11:8] :
                       (flash_digit == 3'd1) ? work_q[7:4] : work_q[3:0];

  // ****************************************************************
  // Menu state machine
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ST_DISP;
      menu_index <= 3'd0;
      screen_index <= 3'd0;
      flash_digit <= 3'd0;
      work_q <= 12'h000;
      point_q <= 2'd0;
      sec5_q <= 1'b1;
      ct_q <= `FPM_CT_RESET;
      vt_q <= `FPM_VT_RESET;
      idle_cnt_q <= 36'h0_0000_0000;
      rot_cnt_q <= 32'h0000_0000;
    end else begin
      if (b1_any || b2_any || both_p)
        idle_cnt_q <= 36'h0_0000_0000;
      else if (state_q != ST_DISP)
        idle_cnt_q <= idle_cnt_q + 36'h0_0000_0001;
      // Bus writes of ratios; panel edits below win in the same cycle
      if (wr_hit && wsel == `FPM_REG_CT)
        ct_q <= avs_writedata;
      if (wr_hit && wsel == `FPM_REG_VT)
        vt_q <= avs_writedata;
      case (state_q)
        ST_DISP: begin
          if (both_p) begin
            flash_digit <= 3'd0;
            work_q <= 12'h000;
            menu_index <= 3'd0;
            state_q <= ctrl_q[`FPM_CTRL_PW_SET] ? ST_PASS : ST_MENU;
          end else if (b1_any || b2_any) begin
            rot_cnt_q <= 32'h0000_0000;
            screen_index <= idx_step(screen_index,
              `FPM_LAST_SCREEN, short_p[0] | short_p[1]);
          end else if (ctrl_q[`FPM_CTRL_ROT_EN]) begin
            if (rot_cnt_q >= rot_q * ROT_UNIT - 1) begin
              rot_cnt_q <= 32'h0000_0000;
              screen_index <= idx_step(screen_index,
                `FPM_LAST_SCREEN, 1'b1);
            end else begin
              rot_cnt_q <= rot_cnt_q + 32'h0000_0001;
            end
          end
        end
        ST_PASS: begin
          if (both_p || idle_cnt_q >= IDLE_CYC - 1) begin
            state_q <= ST_DISP;
          end else if (b2_any) begin
            case (flash_digit)
              3'd0: work_q[11:8] <= bcd_step(cur_nib, b2_up);
              3'd1: work_q[7:4] <= bcd_step(cur_nib, b2_up);
              default: work_q[3:0] <= bcd_step(cur_nib, b2_up);
            endcase
          end else if (b1_any) begin
            if (flash_digit == 3'd2) begin
              flash_digit <= 3'd0;
              work_q <= 12'h000;
              if (work_q == password_q)
                state_q <= ST_MENU;
            end else begin
              flash_digit <= flash_digit + 3'd1;
            end
          end
        end
        ST_MENU: begin
          if (both_p || idle_cnt_q >= IDLE_CYC - 1) begin
            state_q <= ST_DISP;
          end else if (b2_any) begin
            menu_index <= idx_step(menu_index, 3'd6, b2_up);
          end else if (b1_any && menu_index <= 3'd1) begin
            // Only the two ratio menus are edited here
            state_q <= ST_EDIT;
            flash_digit <= 3'd0;
            work_q <= (menu_index == 3'd0) ? ct_q[27:16] : vt_q[27:16];
            point_q <= (menu_index == 3'd0) ? ct_q[29:28] : vt_q[29:28];
            sec5_q <= (menu_index == 3'd0) ? ct_q[2] : vt_q[2];
          end
        end
        ST_EDIT: begin
          if (both_p || idle_cnt_q >= IDLE_CYC - 1) begin
            state_q <= ST_DISP;
          end else if (b2_any) begin
            if (flash_digit == POS_SEC)
              sec5_q <= ~sec5_q;
            else if (flash_digit == POS_WHOLE)
              point_q <= (point_q == 2'd2) ? 2'd0 : point_q + 2'd1;
            else if (flash_digit == 3'd0)
              work_q[11:8] <= bcd_step(cur_nib, b2_up);
            else if (flash_digit == 3'd1)
              work_q[7:4] <= bcd_step(cur_nib, b2_up);
            else
              work_q[3:0] <= bcd_step(cur_nib, b2_up);
          end else if (b1_any) begin
            if (flash_digit == POS_SEC) begin
              // Commit three digits, point and secondary back to store
              if (menu_index == 3'd0)
                ct_q <= {2'b00, point_q, work_q, 13'h0000,
                         sec5_q, 1'b0, 1'b1};
              else
                vt_q <= {2'b00, point_q, work_q, 13'h0000,
                         sec5_q, 1'b0, 1'b1};
              state_q <= ST_MENU;
              flash_digit <= 3'd0;
            end else begin
              flash_digit <= flash_digit + 3'd1;
            end
          end
        end
        default: state_q <= ST_DISP;
      endcase
    end
  end

  // ****************************************************************
  // Bus-only settings and power-up settle timer
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q <= 32'h0000_0000;
      password_q <= 12'h000;
      rot_q <= `FPM_ROT_RESET;
      profile_q <= 32'h0000_0000;
      clock_q <= 32'h0000_0000;
      freq_cnt_q <= 32'h0000_0000;
      meas_settled <= 1'b0;
    end else begin
      if (wr_hit) begin
        case (wsel)
          `FPM_REG_CTRL: ctrl_q <= {29'h0, avs_writedata[2:0]};
          `FPM_REG_PASSWORD: password_q <= avs_writedata[11:0];
          `FPM_REG_DISP: rot_q <= avs_writedata;
          `FPM_REG_PROFILE: profile_q <= avs_writedata;
          `FPM_REG_CLOCK: clock_q <= avs_writedata;
          default: ;
        endcase
      end
      if (freq_cnt_q >= FREQ_CYC - 1)
        meas_settled <= 1'b1;
      else
        freq_cnt_q <= freq_cnt_q + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Avalon-MM answer: one wait cycle, then data and release
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        case (wsel)
          `FPM_REG_CTRL: avs_readdata <= ctrl_q;
          `FPM_REG_STATUS: avs_readdata <= {20'h0, meas_settled,
            state_q, menu_index, screen_index, 1'b0};
          `FPM_REG_PASSWORD: avs_readdata <= {20'h0, password_q};
          `FPM_REG_CT: avs_readdata <= ct_q;
          `FPM_REG_VT: avs_readdata <= vt_q;
          `FPM_REG_DISP: avs_readdata <= rot_q;
          `FPM_REG_PROFILE: avs_readdata <= profile_q;
          `FPM_REG_CLOCK: avs_readdata <= clock_q;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Display markers and channel LEDs
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      programming_mode_marker <= 1'b0;
      current_ratio_menu_marker <= 1'b0;
      voltage_ratio_menu_marker <= 1'b0;
      password_screen <= 1'b0;
      edit_value <= 12'h000;
      relay_output_one <= 1'b0;
      relay_output_two <= 1'b0;
      led_green <= 3'b000;
      led_red <= 3'b000;
      g2_dir_out <= 3'b000;
    end else begin
      programming_mode_marker <= state_q[2] | state_q[3];
      current_ratio_menu_marker <= !state_q[0] && !state_q[1] &&
                                   menu_index == 3'd0;
      voltage_ratio_menu_marker <= !state_q[0] && !state_q[1] &&
                                   menu_index == 3'd1;
      password_screen <= state_q[1];
      edit_value <= work_q;
      // Drive state taken before any NC/NO inversion stage
      relay_output_one <= relay_output_one_in;
      relay_output_two <= relay_output_two_in;
      // One bit sets the whole group; no per-channel direction exists
      g2_dir_out <= {3{ctrl_q[`FPM_CTRL_G2_OUT]}};
      led_green <= ctrl_q[`FPM_CTRL_G2_OUT] ? 3'b000 : g2_signal_in;
      led_red <= ctrl_q[`FPM_CTRL_G2_OUT] ? g2_drive_in : 3'b000;
    end
  end
endmodule

// >>> shared/fpm_consts.vh
// Constants for the two-button front-panel menu controller.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef FPM_CONSTS_VH
`define FPM_CONSTS_VH
// ****************************************************************
// Timing figures in their own units, cycle counts derived from them
// ****************************************************************
`define FPM_CLK_MHZ 200
`define FPM_DEBOUNCE_US 10000
`define FPM_HOLD_US 600000
`define FPM_BOTH_US 1000000
`define FPM_IDLE_S 60
`define FPM_FREQ_S 5
`define FPM_DEBOUNCE_CYC (`FPM_DEBOUNCE_US * `FPM_CLK_MHZ)
`define FPM_HOLD_CYC (`FPM_HOLD_US * `FPM_CLK_MHZ)
`define FPM_BOTH_CYC (`FPM_BOTH_US * `FPM_CLK_MHZ)
`define FPM_IDLE_CYC (`FPM_IDLE_S * 64'd1000000 * `FPM_CLK_MHZ)
`define FPM_FREQ_CYC (`FPM_FREQ_S * 1000000 * `FPM_CLK_MHZ)
// ****************************************************************
// Register word indices (byte address bits 5:2)
// ****************************************************************
`define FPM_REG_CTRL 4'h0
`define FPM_REG_STATUS 4'h1
`define FPM_REG_PASSWORD 4'h2
`define FPM_REG_CT 4'h3
`define FPM_REG_VT 4'h4
`define FPM_REG_DISP 4'h5
`define FPM_REG_PROFILE 4'h6
`define FPM_REG_CLOCK 4'h7
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define FPM_CTRL_G2_OUT 0
`define FPM_CTRL_ROT_EN 1
`define FPM_CTRL_PW_SET 2
`define FPM_CT_RESET 32'h0005_0005
`define FPM_VT_RESET 32'h0000_0000
`define FPM_ROT_RESET 32'h0000_0008
`define FPM_LAST_SCREEN 3'd7
`endif

// >>> dv/fpm_menu_asserts.sv
// Checker for the front-panel controller: bus, LEDs, menus, timers.
// Bound to the controller; sees its ports only, with shortened counts.
module fpm_menu_asserts #(
  parameter FREQ_CYC = 200,
  parameter IDLE_CYC = 1000
) (
  // Clock, reset and buttons
  input wire sys_clk,
  input wire reset_n,
  input wire button_one,
  input wire button_two,
  // Sense and drive inputs
  input wire relay_output_one_in,
  input wire relay_output_two_in,
  input wire [2:0] g2_signal_in,
  input wire [2:0] g2_drive_in,
  // Bus handshake
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Panel outputs
  input wire programming_mode_marker,
  input wire current_ratio_menu_marker,
  input wire voltage_ratio_menu_marker,
  input wire relay_output_one,
  input wire relay_output_two,
  input wire [2:0] menu_index,
  input wire [2:0] flash_digit,
  input wire password_screen,
  input wire [2:0] led_green,
  input wire [2:0] led_red,
  input wire [2:0] g2_dir_out,
  input wire meas_settled
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Helper counters and properties
  // ****************************************************************
  logic [31:0] set_q;
  logic [31:0] idle_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Age since reset and quiet time since any raw button activity
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      set_q <= 32'h0000_0000;
      idle_q <= 32'h0000_0000;
    end else begin
      if (set_q < FREQ_CYC + 8) set_q <= set_q + 1;
      if (button_one || button_two) idle_q <= 32'h0000_0000;
      else if (idle_q < IDLE_CYC + 64) idle_q <= idle_q + 1;
    end
  end

  a_dir_whole: assert property (
    g2_dir_out == 3'b000 || g2_dir_out == 3'b111)
    else $error("group two direction mixed");
  // Past value is taken only when it was outside reset
  a_relay_copy: assert property ($past(reset_n) |->
    {relay_output_one, relay_output_two} ==
    $past({relay_output_one_in, relay_output_two_in}))
    else $error("relay status does not follow drive");
  a_green_follow: assert property (
    (!g2_dir_out[0] && $stable(g2_signal_in))[*3]
    |-> led_green == g2_signal_in) else $error("green led wrong");
  a_red_follow: assert property (
    (g2_dir_out[0] && $stable(g2_drive_in))[*3]
    |-> led_red == g2_drive_in) else $error("red led wrong");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than a cycle");
  // One cycle of lag between marker and menu index is tolerated
  a_ct_marker: assert property (current_ratio_menu_marker |->
    (menu_index == 3'd0 || $past(menu_index) == 3'd0) &&
    (programming_mode_marker || $past(programming_mode_marker)))
    else $error("current marker outside its menu");
  a_vt_marker: assert property (voltage_ratio_menu_marker |->
    (menu_index == 3'd1 || $past(menu_index) == 3'd1) &&
    (programming_mode_marker || $past(programming_mode_marker)))
    else $error("voltage marker outside its menu");
  a_menu_range: assert property (
    menu_index <= 3'd6 && flash_digit <= 3'd4)
    else $error("menu or digit index out of range");
  a_prog_entry: assert property ($rose(programming_mode_marker) &&
    !$past(password_screen) |-> $past(button_one && button_two, 2))
    else $error("programming entered without both buttons");
  a_settle_time: assert property (
    (set_q < FREQ_CYC - 4) ? !meas_settled :
    (set_q < FREQ_CYC + 4 || meas_settled)) else $error("settle flag timing");
  a_idle_exit: assert property (idle_q == IDLE_CYC + 48 |->
    !programming_mode_marker) else $error("no idle exit");
  c_prog: cover property ($rose(programming_mode_marker));
  c_pass: cover property ($rose(password_screen));
  c_vt: cover property (voltage_ratio_menu_marker);
  c_red: cover property (led_red != 3'b000);
endmodule

// >>> dv/fpm_operator.sv
// Operator model: a person pressing the two front-panel buttons.
// Driven from the bench by task call; contacts bounce on each press.
module fpm_operator (
  // Clock
  input wire sys_clk,
  // Buttons, high while pressed
  output logic button_one,
  output logic button_two
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Press task
  // ****************************************************************
  initial begin
    button_one = 1'b0;
    button_two = 1'b0;
  end

  // Press with bounce, hold, release, then let the panel settle.
  task automatic press(input bit one, input bit two, input int hold);
    begin
      @(posedge sys_clk);
      button_one <= one;
      button_two <= two;
      @(posedge sys_clk);
      button_one <= 1'b0;
      button_two <= 1'b0;
      @(posedge sys_clk);
      button_one <= one;
      button_two <= two;
      repeat (hold) @(posedge sys_clk);
      button_one <= 1'b0;
      button_two <= 1'b0;
      repeat (24) @(posedge sys_clk);
    end
  endtask
endmodule

// >>> dv/testbench.sv
// Testbench for the front-panel controller with an operator model.
// Counts are shortened; bus reads are scored from a queue of notes.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %0t read %h expected %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals, instances and processes
  // ****************************************************************
  localparam int IDLE_CYC = 1000;
  localparam int FREQ_CYC = 200;
  localparam int SH = 14;
  localparam int LG = 70;
  localparam int BT = 130;
  logic sys_clk, reset_n, avs_read, avs_write;
  logic relay_output_one_in, relay_output_two_in;
  logic [2:0] g2_signal_in, g2_drive_in, s;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata;
  wire button_one, button_two, avs_waitrequest, programming_mode_marker;
  wire current_ratio_menu_marker, voltage_ratio_menu_marker;
  wire relay_output_one, relay_output_two, password_screen, meas_settled;
  wire [2:0] menu_index, screen_index, flash_digit, led_green, led_red;
  wire [2:0] g2_dir_out;
  wire [11:0] edit_value;
  wire [31:0] avs_readdata;
  logic [63:0] expq[$];
  logic [63:0] e;
  logic [31:0] v;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'h99e45dac;

  fpm_menu #(.DEB_CYC(4), .HOLD_CYC(50), .BOTH_CYC(100),
    .IDLE_CYC(IDLE_CYC), .FREQ_CYC(FREQ_CYC), .ROT_UNIT(20)) i_fpm_menu (
    .sys_clk, .reset_n, .button_one, .button_two, .relay_output_one_in,
    .relay_output_two_in, .g2_signal_in, .g2_drive_in, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .programming_mode_marker, .current_ratio_menu_marker,
    .voltage_ratio_menu_marker, .relay_output_one, .relay_output_two,
    .menu_index, .screen_index, .flash_digit, .password_screen,
    .edit_value, .led_green, .led_red, .g2_dir_out, .meas_settled);
  fpm_operator i_fpm_operator (.sys_clk, .button_one, .button_two);

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Watchdog, well beyond the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    test_done;
  end

  // Random sense and drive levels, held five cycles so LEDs can settle
  initial begin
    {relay_output_one_in, relay_output_two_in} = 2'b00;
    {g2_signal_in, g2_drive_in} = 6'b00_0000;
    forever begin
      repeat (5) @(posedge sys_clk);
      {relay_output_one_in, relay_output_two_in, g2_signal_in,
        g2_drive_in} <= 8'($random(seed));
    end
  end

  // Read answers are scored against the oldest note
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = expq.pop_front();
      `CHK(avs_readdata & e[63:32], e[31:0] & e[63:32])
    end
  end

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input bit w, input [5:0] a, input [31:0] d,
                     input [31:0] m);
    int n;
    begin
      n = 0;
      if (!w) expq.push_back({m, d});
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      if (w) avs_writedata <= d;
      do begin
        @(posedge sys_clk);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) begin
        num_errors++;
        $display("FAIL %0t bus answer missing", $time);
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task automatic wr(input [5:0] a, input [31:0] d);
    bus(1'b1, a, d, 32'h0000_0000);
  endtask

  task automatic rd(input [5:0] a, input [31:0] v, input [31:0] m);
    bus(1'b0, a, v, m);
  endtask

  task automatic pr(input bit one, input bit two, input int hold);
    i_fpm_operator.press(one, two, hold);
  endtask

  task test_done;
    begin
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Main sequence: registers, display scrolling, menus, password
  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(6'h04, 32'h0000_0000, 32'h0000_0800);
    rd(6'h0C, 32'h0005_0005, 32'hFFFF_FFFF);
    rd(6'h14, 32'h0000_0008, 32'hFFFF_FFFF);
    wr(6'h20, $random(seed));
    rd(6'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(6'h00, 32'h0000_0001);
    rd(6'h00, 32'h0000_0001, 32'h0000_0007);
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      wr(6'(6'h18 + 4 * i), v);
      rd(6'(6'h18 + 4 * i), v, 32'hFFFF_FFFF);
    end
    s = 3'd0;
    for (int i = 0; i < 5; i++) begin
      pr(i == 0 || i == 2, i == 1 || i > 2, (i < 2) ? SH : LG);
      s = (i < 2) ? s + 3'd1 : s - 3'd1;
      rd(6'h04, {24'h0, 1'b1, 3'b000, s, 1'b0}, 32'h0000_078E);
    end
    pr(1'b1, 1'b1, BT);
    rd(6'h04, 32'h0000_0200, 32'h0000_07F0);
    for (int i = 1; i < 8; i++) begin
      pr(1'b0, 1'b1, SH);
      rd(6'h04, 32'h0000_0200 | 32'((i % 7) << 4), 32'h0000_07F0);
    end
    pr(1'b1, 1'b0, SH);
    rd(6'h04, 32'h0000_0400, 32'h0000_07F0);
    pr(1'b0, 1'b1, SH);
    `CHK(edit_value, 12'h105)
    repeat (3) pr(1'b1, 1'b0, SH);
    // Point shift at the whole number, then secondary toggle, commit
    repeat (2) begin
      pr(1'b0, 1'b1, SH);
      pr(1'b1, 1'b0, SH);
    end
    rd(6'h04, 32'h0000_0200, 32'h0000_07F0);
    rd(6'h0C, 32'h1105_0001, 32'h3FFF_0005);
    pr(1'b1, 1'b1, BT);
    rd(6'h04, 32'h0000_0880, 32'h0000_0F80);
    wr(6'h04, 32'hFFFF_FFFF);
    rd(6'h04, 32'h0000_0080, 32'h0000_0780);
    pr(1'b1, 1'b1, BT);
    rd(6'h04, 32'h0000_0200, 32'h0000_0780);
    repeat (IDLE_CYC + 80) @(posedge sys_clk);
    rd(6'h04, 32'h0000_0080, 32'h0000_0780);
    wr(6'h08, 32'h0000_0111);
    wr(6'h00, 32'h0000_0004);
    pr(1'b1, 1'b1, BT);
    rd(6'h04, 32'h0000_0100, 32'h0000_0780);
    repeat (3) pr(1'b1, 1'b0, SH);
    rd(6'h04, 32'h0000_0100, 32'h0000_0780);
    repeat (3) begin
      pr(1'b0, 1'b1, SH);
      pr(1'b1, 1'b0, SH);
    end
    rd(6'h04, 32'h0000_0200, 32'h0000_07F0);
    pr(1'b1, 1'b1, BT);
    rd(6'h04, 32'h0000_0080, 32'h0000_0780);
    // Rotation every 20 cycles: two steps from screen 7 within 50
    wr(6'h14, 32'h0000_0001);
    wr(6'h00, 32'h0000_0002);
    repeat (50) @(posedge sys_clk);
    rd(6'h04, 32'h0000_0082, 32'h0000_078E);
    test_done;
  end
endmodule

bind fpm_menu fpm_menu_asserts #(.FREQ_CYC(FREQ_CYC), .IDLE_CYC(IDLE_CYC))
  u_chk (.sys_clk, .reset_n, .button_one, .button_two,
  .relay_output_one_in, .relay_output_two_in, .g2_signal_in, .g2_drive_in,
  .avs_read, .avs_write, .avs_waitrequest, .programming_mode_marker,
  .current_ratio_menu_marker, .voltage_ratio_menu_marker, .relay_output_one,
  .relay_output_two, .menu_index, .flash_digit, .password_screen,
  .led_green, .led_red, .g2_dir_out, .meas_settled);
